// [design/simd_int_pkg.sv]
package simd_int_pkg;
  localparam int VEC_W = 128;
  localparam int MM_W = 64;
  localparam int OP_W = 6;
  localparam logic [3:0] ALIGN_MASK = 4'hf;
  localparam logic [7:0] MAX_BYTE_SHIFT = 8'h0f;
  localparam logic [127:0] ZERO_VEC = 128'h0;

  typedef enum logic [5:0] {
    OP_VEC_MOVE_ALIGNED,
    OP_VEC_MOVE_UNALIGNED,
    OP_QUADWORD_ADD,
    OP_QUADWORD_SUBTRACT,
    OP_UNSIGNED_WIDENING_MULTIPLY,
    OP_LOW_WORD_SHUFFLE,
    OP_HIGH_WORD_SHUFFLE,
    OP_DOUBLEWORD_SHUFFLE,
    OP_LEFT_BYTE_SHIFT,
    OP_RIGHT_BYTE_SHIFT,
    OP_HIGH_QUADWORD_UNPACK,
    OP_LOW_QUADWORD_UNPACK,
    OP_MULTIMEDIA_TO_VECTOR_MOVE,
    OP_VECTOR_TO_MULTIMEDIA_MOVE,
    OP_PACKED_BYTE_ADD,
    OP_PACKED_WORD_ADD,
    OP_PACKED_DWORD_ADD,
    OP_PACKED_BYTE_SUBTRACT,
    OP_PACKED_WORD_SUBTRACT,
    OP_PACKED_DWORD_SUBTRACT,
    OP_PACKED_AND,
    OP_PACKED_OR,
    OP_PACKED_XOR,
    OP_LEGACY_WORD_SHUFFLE
  } op_e;

  typedef enum logic [1:0] {
    MEM_NONE,
    MEM_LOAD,
    MEM_STORE
  } mem_e;

  typedef struct packed {
    logic valid;
    op_e op;
    logic wide;
    mem_e mem;
    logic [31:0] addr;
    logic [7:0] imm;
    logic [127:0] dst;
    logic [127:0] src;
  } req_s;

  typedef struct packed {
    logic valid;
    logic gp_fault;
    logic illegal;
    logic wr_vector;
    logic wr_multimedia;
    logic store;
    logic [127:0] data;
  } rsp_s;
endpackage

// [design/simd_integer_datapath.sv]
`timescale 1ns/1ps
// Functional notes
// - Aligned move faults on unaligned memory address.
// - Unaligned move never checks alignment.
// - Quadword add wraps per 64-bit lane.
// - Quadword subtract wraps, destination minus source.
// - Narrow multiply: low dwords, 64-bit product.
// - Wide multiply: dwords 0 and 2 pairwise.
// - Low-word shuffle by 2-bit immediate fields.
// - High-word shuffle by 2-bit immediate fields.
// - Doubleword shuffle by 2-bit immediate fields.
// - Left byte shift, zero-fill low bytes.
// - Right byte shift, zero-fill high bytes.
// - High unpack: dst high low, src high high.
// - Low unpack: keep dst low, src low high.
// - Multimedia to vector copies into low quadword.
// - Vector to multimedia copies low quadword only.
// - Legacy ops widen to 128 bits, not word shuffle.
// - Add, subtract, multiply, logic: wide to vector file, narrow to multimedia; legacy shuffle narrow to multimedia, wide illegal.
module simd_integer_datapath (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire simd_int_pkg::req_s req_in,
  output simd_int_pkg::rsp_s rsp_out
);

  typedef struct packed {
    simd_int_pkg::rsp_s rsp;
  } state_s;

  state_s state;
  state_s next_state;

  // Picks one 16-bit word of a quadword
  function automatic logic [15:0] pick_word(input logic [63:0] q,
                                            input logic [1:0] sel);
    pick_word = q[sel*16 +: 16];
  endfunction

  // Picks one 32-bit element of a vector
  function automatic logic [31:0] pick_dword(input logic [127:0] v,
                                             input logic [1:0] sel);
    pick_dword = v[sel*32 +: 32];
  endfunction

  // Shuffles the four words of a quadword under an immediate
  function automatic logic [63:0] shuf_words(input logic [63:0] q,
                                             input logic [7:0] imm);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*16 +: 16] = pick_word(q, imm[i*2 +: 2]);
    end
    shuf_words = r;
  endfunction

  // Lane-wise add or subtract at a lane width in bytes
  function automatic logic [127:0] lane_arith(input logic [127:0] a,
                                              input logic [127:0] b,
                                              input int lane_bytes,
                                              input logic sub);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (i % lane_bytes == 0) begin
        unique case (lane_bytes)
          1: r[i*8 +: 8] = sub ? a[i*8 +: 8] - b[i*8 +: 8]
                               : a[i*8 +: 8] + b[i*8 +: 8];
          2: r[i*8 +: 16] = sub ? a[i*8 +: 16] - b[i*8 +: 16]
                                : a[i*8 +: 16] + b[i*8 +: 16];
          4: r[i*8 +: 32] = sub ? a[i*8 +: 32] - b[i*8 +: 32]
                                : a[i*8 +: 32] + b[i*8 +: 32];
          default: r[i*8 +: 64] = sub ? a[i*8 +: 64] - b[i*8 +: 64]
                                      : a[i*8 +: 64] + b[i*8 +: 64];
        endcase
      end
    end
    lane_arith = r;
  endfunction

  // Narrow forms only see and produce the low quadword
  function automatic logic [127:0] narrow(input logic [127:0] v,
                                          input logic wide);
    narrow = wide ? v : {64'h0, v[63:0]};
  endfunction

  logic [127:0] a;
  logic [127:0] b;
  logic [127:0] res;
  logic [7:0] cnt;
  logic gp;
  logic bad;
  logic to_vec;
  logic to_mm;
  logic is_store;

  always_comb begin
    a = narrow(req_in.dst, req_in.wide);
    b = narrow(req_in.src, req_in.wide);
    res = simd_int_pkg::ZERO_VEC;
    cnt = req_in.imm;
    gp = 1'b0;
    bad = 1'b0;
    is_store = 1'b0;
    to_vec = req_in.wide;
    to_mm = !req_in.wide;
    unique case (req_in.op)
      simd_int_pkg::OP_VEC_MOVE_ALIGNED,
      simd_int_pkg::OP_VEC_MOVE_UNALIGNED: begin
        res = req_in.src;
        to_vec = 1'b1;
        to_mm = 1'b0;
        if (req_in.mem == simd_int_pkg::MEM_STORE) begin
          is_store = 1'b1;
          to_vec = 1'b0;
        end
        if (req_in.op == simd_int_pkg::OP_VEC_MOVE_ALIGNED &&
            req_in.mem != simd_int_pkg::MEM_NONE &&
            (req_in.addr[3:0] & simd_int_pkg::ALIGN_MASK) != 4'h0) begin
          gp = 1'b1;
        end
        // Unaligned form skips the check entirely
      end
      simd_int_pkg::OP_QUADWORD_ADD: begin
        res = narrow(lane_arith(a, b, 8, 1'b0), req_in.wide);
      end
      simd_int_pkg::OP_QUADWORD_SUBTRACT: begin
        res = narrow(lane_arith(a, b, 8, 1'b1), req_in.wide);
      end
      simd_int_pkg::OP_UNSIGNED_WIDENING_MULTIPLY: begin
        res[63:0] = 64'(a[31:0]) * 64'(b[31:0]);
        if (req_in.wide) begin
          res[127:64] = 64'(a[95:64]) * 64'(b[95:64]);
        end
      end
      simd_int_pkg::OP_LOW_WORD_SHUFFLE: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        res = {req_in.src[127:64],
               shuf_words(req_in.src[63:0], req_in.imm)};
      end
      simd_int_pkg::OP_HIGH_WORD_SHUFFLE: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        res = {shuf_words(req_in.src[127:64], req_in.imm),
               req_in.src[63:0]};
      end
      simd_int_pkg::OP_DOUBLEWORD_SHUFFLE: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        for (int i = 0; i < 4; i++) begin
          res[i*32 +: 32] = pick_dword(req_in.src,
                                       req_in.imm[i*2 +: 2]);
        end
      end
      simd_int_pkg::OP_LEFT_BYTE_SHIFT: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        if (cnt <= simd_int_pkg::MAX_BYTE_SHIFT) begin
          res = req_in.src << {cnt[3:0], 3'h0};
        end
        // Larger counts leave the zero default
      end
      simd_int_pkg::OP_RIGHT_BYTE_SHIFT: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        if (cnt <= simd_int_pkg::MAX_BYTE_SHIFT) begin
          res = req_in.src >> {cnt[3:0], 3'h0};
        end
      end
      simd_int_pkg::OP_HIGH_QUADWORD_UNPACK: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        res = {req_in.src[127:64], req_in.dst[127:64]};
      end
      simd_int_pkg::OP_LOW_QUADWORD_UNPACK: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        res = {req_in.src[63:0], req_in.dst[63:0]};
      end
      simd_int_pkg::OP_MULTIMEDIA_TO_VECTOR_MOVE: begin
        to_vec = 1'b1;
        to_mm = 1'b0;
        res = {64'h0, req_in.src[63:0]};
      end
      simd_int_pkg::OP_VECTOR_TO_MULTIMEDIA_MOVE: begin
        to_vec = 1'b0;
        to_mm = 1'b1;
        res = {64'h0, req_in.src[63:0]};
      end
      simd_int_pkg::OP_PACKED_BYTE_ADD: begin
        res = narrow(lane_arith(a, b, 1, 1'b0), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_WORD_ADD: begin
        res = narrow(lane_arith(a, b, 2, 1'b0), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_DWORD_ADD: begin
        res = narrow(lane_arith(a, b, 4, 1'b0), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_BYTE_SUBTRACT: begin
        res = narrow(lane_arith(a, b, 1, 1'b1), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_WORD_SUBTRACT: begin
        res = narrow(lane_arith(a, b, 2, 1'b1), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_DWORD_SUBTRACT: begin
        res = narrow(lane_arith(a, b, 4, 1'b1), req_in.wide);
      end
      simd_int_pkg::OP_PACKED_AND: begin
        res = a & b;
      end
      simd_int_pkg::OP_PACKED_OR: begin
        res = a | b;
      end
      simd_int_pkg::OP_PACKED_XOR: begin
        res = a ^ b;
      end
      simd_int_pkg::OP_LEGACY_WORD_SHUFFLE: begin
        if (req_in.wide) begin
          bad = 1'b1;
        end else begin
          res = {64'h0, shuf_words(req_in.src[63:0], req_in.imm)};
        end
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.rsp.valid = req_in.valid;
    next_state.rsp.gp_fault = req_in.valid && gp;
    next_state.rsp.illegal = req_in.valid && bad;
    // A fault or illegal form suppresses every write
    next_state.rsp.wr_vector = req_in.valid && !gp && !bad && to_vec;
    next_state.rsp.wr_multimedia = req_in.valid && !gp && !bad && to_mm;
    next_state.rsp.store = req_in.valid && !gp && !bad && is_store;
    if (req_in.valid) begin
      next_state.rsp.data = res;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign rsp_out = state.rsp;

endmodule

// [test/simd_dp_assertions.sv]
`timescale 1ns/1ps
module simd_dp_checker (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire simd_int_pkg::req_s req_in,
  input wire simd_int_pkg::rsp_s rsp_out
);
  simd_int_pkg::req_s p;
  // Copy of the request from its taking edge
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      p <= '0;
    else if (clk_en_in && req_in.valid)
      p <= req_in;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_take(simd_int_pkg::op_e o);
    clk_en_in && req_in.valid && req_in.op == o;
  endsequence
  AST_ALIGN_FAULT: assert property (
    s_take(simd_int_pkg::OP_VEC_MOVE_ALIGNED) ##0 req_in.addr[3:0] != 4'h0
    ##0 req_in.mem != simd_int_pkg::MEM_NONE |=> rsp_out.gp_fault)
    else $error("aligned move without fault");
  AST_NO_ALIGN_CHECK: assert property (
    s_take(simd_int_pkg::OP_VEC_MOVE_UNALIGNED)
    |=> !rsp_out.gp_fault && rsp_out.data == p.src)
    else $error("unaligned move wrong");
  AST_QADD_WIDE: assert property (
    s_take(simd_int_pkg::OP_QUADWORD_ADD) ##0 req_in.wide
    |=> rsp_out.data == {p.dst[127:64] + p.src[127:64],
      p.dst[63:0] + p.src[63:0]})
    else $error("quadword add wrong");
  AST_QSUB_NARROW: assert property (
    s_take(simd_int_pkg::OP_QUADWORD_SUBTRACT) ##0 !req_in.wide
    |=> rsp_out.data == {64'h0, p.dst[63:0] - p.src[63:0]})
    else $error("narrow subtract wrong");
  AST_MUL_HIGH: assert property (
    s_take(simd_int_pkg::OP_UNSIGNED_WIDENING_MULTIPLY) ##0 req_in.wide
    |=> rsp_out.data[127:64] == p.dst[95:64] * p.src[95:64])
    else $error("wide multiply high product wrong");
  AST_UNPACK_HIGH: assert property (
    s_take(simd_int_pkg::OP_HIGH_QUADWORD_UNPACK) |=> rsp_out.data ==
    {$past(req_in.src[127:64]), $past(req_in.dst[127:64])})
    else $error("high unpack wrong");
  AST_SHIFT_CLEAR: assert property (
    s_take(simd_int_pkg::OP_RIGHT_BYTE_SHIFT) ##0 req_in.imm > 8'h0f
    |=> rsp_out.data == 128'h0)
    else $error("oversized shift not zero");
  AST_TO_MULTIMEDIA: assert property (
    s_take(simd_int_pkg::OP_VECTOR_TO_MULTIMEDIA_MOVE) |=>
    rsp_out.wr_multimedia && !rsp_out.wr_vector
    && rsp_out.data[63:0] == p.src[63:0])
    else $error("vector to multimedia move wrong");
endmodule
bind simd_integer_datapath simd_dp_checker u_chk (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .req_in(req_in),
  .rsp_out(rsp_out));

// [test/core_regfile.sv]
`timescale 1ns/1ps
module core_regfile (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire simd_int_pkg::rsp_s rsp_in,
  output logic [127:0] vec_out,
  output logic [63:0] mm_out
);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vec_out <= '0;
      mm_out <= '0;
    end else if (clk_en_in && rsp_in.valid) begin
      if (rsp_in.wr_vector) vec_out <= rsp_in.data;
      if (rsp_in.wr_multimedia) mm_out <= rsp_in.data[63:0];
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b0;
  simd_int_pkg::req_s req_in = '0;
  simd_int_pkg::rsp_s rsp_out;
  simd_int_pkg::rsp_s q[$];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  simd_integer_datapath u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in), .req_in(req_in), .rsp_out(rsp_out));
  core_regfile u_core (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in), .rsp_in(rsp_out), .vec_out(), .mm_out());
  always #4 mclk_in = ~mclk_in;
  function automatic simd_int_pkg::rsp_s ref_of(simd_int_pkg::req_s r);
    simd_int_pkg::rsp_s e;
    logic [127:0] d;
    logic [127:0] s;
    logic [127:0] y;
    logic ar;
    d = r.dst;
    s = r.src;
    y = '0;
    ar = 1'b0;
    e = '0;
    e.valid = 1'b1;
    e.wr_vector = 1'b1;
    case (r.op)
      simd_int_pkg::OP_VEC_MOVE_ALIGNED,
      simd_int_pkg::OP_VEC_MOVE_UNALIGNED: begin
        y = s;
        e.store = r.mem == simd_int_pkg::MEM_STORE;
        e.wr_vector = !e.store;
        e.gp_fault = r.op == simd_int_pkg::OP_VEC_MOVE_ALIGNED &&
          r.mem != simd_int_pkg::MEM_NONE && r.addr[3:0] != 4'h0;
      end
      simd_int_pkg::OP_QUADWORD_ADD: begin
        y = {d[127:64] + s[127:64], d[63:0] + s[63:0]};
        ar = 1'b1;
      end
      simd_int_pkg::OP_QUADWORD_SUBTRACT: begin
        y = {d[127:64] - s[127:64], d[63:0] - s[63:0]};
        ar = 1'b1;
      end
      simd_int_pkg::OP_UNSIGNED_WIDENING_MULTIPLY: begin
        y = {64'(d[95:64]) * s[95:64], 64'(d[31:0]) * s[31:0]};
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_BYTE_ADD: begin
        for (int i = 0; i < 16; i++) y[8*i+:8] = d[8*i+:8] + s[8*i+:8];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_WORD_ADD: begin
        for (int i = 0; i < 8; i++) y[16*i+:16] = d[16*i+:16] + s[16*i+:16];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_DWORD_ADD: begin
        for (int i = 0; i < 4; i++) y[32*i+:32] = d[32*i+:32] + s[32*i+:32];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_BYTE_SUBTRACT: begin
        for (int i = 0; i < 16; i++) y[8*i+:8] = d[8*i+:8] - s[8*i+:8];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_WORD_SUBTRACT: begin
        for (int i = 0; i < 8; i++) y[16*i+:16] = d[16*i+:16] - s[16*i+:16];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_DWORD_SUBTRACT: begin
        for (int i = 0; i < 4; i++) y[32*i+:32] = d[32*i+:32] - s[32*i+:32];
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_AND: begin
        y = d & s;
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_OR: begin
        y = d | s;
        ar = 1'b1;
      end
      simd_int_pkg::OP_PACKED_XOR: begin
        y = d ^ s;
        ar = 1'b1;
      end
      simd_int_pkg::OP_LEGACY_WORD_SHUFFLE: begin
        e.illegal = r.wide;
        if (!r.wide)
          for (int i = 0; i < 4; i++) y[16*i+:16] = s[16*r.imm[2*i+:2]+:16];
        ar = 1'b1;
      end
      simd_int_pkg::OP_LOW_WORD_SHUFFLE: begin
        y = s;
        for (int i = 0; i < 4; i++) y[16*i+:16] = s[16*r.imm[2*i+:2]+:16];
      end
      simd_int_pkg::OP_HIGH_WORD_SHUFFLE: begin
        y = s;
        for (int i = 0; i < 4; i++) y[64+16*i+:16] = s[64+16*r.imm[2*i+:2]+:16];
      end
      simd_int_pkg::OP_DOUBLEWORD_SHUFFLE:
        for (int i = 0; i < 4; i++) y[32*i+:32] = s[32*r.imm[2*i+:2]+:32];
      simd_int_pkg::OP_LEFT_BYTE_SHIFT: y = s << (8 * r.imm);
      simd_int_pkg::OP_RIGHT_BYTE_SHIFT: y = s >> (8 * r.imm);
      simd_int_pkg::OP_HIGH_QUADWORD_UNPACK: y = {s[127:64], d[127:64]};
      simd_int_pkg::OP_LOW_QUADWORD_UNPACK: y = {s[63:0], d[63:0]};
      simd_int_pkg::OP_MULTIMEDIA_TO_VECTOR_MOVE,
      simd_int_pkg::OP_VECTOR_TO_MULTIMEDIA_MOVE: begin
        y = {64'h0, s[63:0]};
        e.wr_multimedia = r.op == simd_int_pkg::OP_VECTOR_TO_MULTIMEDIA_MOVE;
        e.wr_vector = !e.wr_multimedia;
      end
      default: e.illegal = 1'b1;
    endcase
    if (ar && !r.wide) begin
      y[127:64] = 64'h0;
      e.wr_vector = 1'b0;
      e.wr_multimedia = 1'b1;
    end
    if (e.gp_fault || e.illegal) {e.wr_vector, e.wr_multimedia, e.store} = 3'h0;
    e.data = y;
    return e;
  endfunction
  task automatic chk(simd_int_pkg::rsp_s e, simd_int_pkg::rsp_s g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error rsp_out expected %h seen %h", e, g);
    end
  endtask
  task automatic issue(simd_int_pkg::req_s r);
    bit en;
    req_in <= r;
    q.push_back(ref_of(r));
    do begin
      en = $urandom_range(0, 3) != 0;
      clk_en_in <= en;
      @(posedge mclk_in);
    end while (!en);
  endtask
  task automatic finish_test();
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles > 4000) begin
      failures++;
      finish_test();
    end
    if (rst_n_in && clk_en_in && rsp_out.valid === 1'b1)
      chk(q.size() > 0 ? q.pop_front() : simd_int_pkg::rsp_s'(0), rsp_out);
  end
  initial begin
    simd_int_pkg::req_s r;
    int k;
    void'($urandom(19865));
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      k = $urandom_range(0, 23);
      r.valid = 1'b1;
      r.op = simd_int_pkg::op_e'(k);
      r.wide = k inside {[2:4], [14:23]} ? 1'($urandom_range(0, 1)) : 1'b1;
      r.mem = k < 2 ? simd_int_pkg::mem_e'($urandom_range(0, 2)) : simd_int_pkg::MEM_NONE;
      r.addr = $urandom;
      if (n[0]) r.addr[3:0] = 4'h0;
      r.imm = $urandom_range(0, 1) ? 8'($urandom_range(0, 20)) : 8'($urandom);
      r.dst = {$urandom, $urandom, $urandom, $urandom};
      r.src = {$urandom, $urandom, $urandom, $urandom};
      issue(r);
    end
    req_in <= '0;
    clk_en_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    finish_test();
  end
endmodule
